/* File: hw/dor_top.sv */
// digital output stage with polarity, manual forcing and output routing
//
// Local design decisions: the register addresses and the AHB-Lite register port.
`timescale 1ns/1ps

// Overview of operation
// - output n driven from command bit 15+n
// - bit 0 drives brake, 1-15 reserved
// - polarity bit set inverts the level of brake and unrouted outputs
// - manual enable selects manual value for brake and unrouted outputs
// - readback holds pattern applied to the pins
// - LED enable bits gate green and red flashing
// - routing mode only when enable equals one
// - routed signal gated by chosen command bit
// - route entry: high byte source, low byte bit
// - entry 0 software pwm, then outputs 1..n
// - entry bit 7 inverts the gating bit
// - entry value FFF disables routing there
// - source 00 constant one, 01 constant zero
// - sources 02-08 divided encoder increment pulses
// - sources 09-0F divided position increment pulses
// - source 10 brake pwm, 11 inverted pwm
// - divider one: pulse per single increment
// - software pwm 2 kHz, others 500 Hz
// - pwm frequency accepted only 50..20000 Hz
// - duty 2..100 percent, 100 always on
module dor_top
    import dor_pkg::*;
#(
    parameter int SW_PULSE  = SW_PULSE_CYC,
    parameter int OUT_PULSE = OUT_PULSE_CYC,
    parameter int LED_BLINK = LED_BLINK_CYC
)(
    input  wire logic               clock,
    input  wire logic               rst_b,
    input  wire logic               hsel,
    input  wire logic [31:0]        haddr,
    input  wire logic [1:0]         htrans,
    input  wire logic               hwrite,
    input  wire logic [2:0]         hsize,
    input  wire logic [31:0]        hwdata,
    input  wire logic               hready,
    output logic [31:0]             hrdata,
    output logic                    hreadyout,
    output logic                    hresp,
    input  wire logic [31:0]        encoderCountValue,
    input  wire logic [31:0]        actualPositionValue,
    input  wire logic               faultActive,
    output logic [NUM_OUT-1:0]      outPin,
    output logic                    brakePin,
    output logic                    swPwmPin,
    output logic                    ledGreen,
    output logic                    ledRed
);

    logic [31:0]        cmd_q;
    logic [31:0]        pol_q;
    logic [31:0]        manEn_q;
    logic [31:0]        manVal_q;
    logic [31:0]        routeEn_q;
    logic [31:0]        ledEn_q;
    logic [31:0]        pwmFreq_q;
    logic [31:0]        pwmDuty_q;
    logic [31:0]        readback_q;
    dor_route_t         route_q [NUM_ROUTE];
    logic [7:0]         addr_q;
    logic               wrPend_q;
    logic               rdPend_q;
    logic [31:0]        hrdata_q;
    logic               hreadyout_q;
    logic [31:0]        rdMux;
    logic               addrPhase;
    logic [NUM_OUT-1:0] outPin_q;
    logic               brakePin_q;
    logic               swPwmPin_q;
    logic               ledGreen_q;
    logic               ledRed_q;

    assign hrdata    = hrdata_q;
    assign hreadyout = hreadyout_q;
    assign hresp     = 1'b0;
    assign outPin    = outPin_q;
    assign brakePin  = brakePin_q;
    assign swPwmPin  = swPwmPin_q;
    assign ledGreen  = ledGreen_q;
    assign ledRed    = ledRed_q;

    assign addrPhase = hsel && htrans[1] && hready;

    // bus phases; reads take one wait state so writes land first
    always_ff @(posedge clock)
    begin
        if (!rst_b)
        begin
            addr_q      <= 8'h00;
            wrPend_q    <= 1'b0;
            rdPend_q    <= 1'b0;
            hreadyout_q <= 1'b1;
            hrdata_q    <= WORD_RESET;
        end
        else if (rdPend_q)
        begin
            rdPend_q    <= 1'b0;
            hreadyout_q <= 1'b1;
            hrdata_q    <= rdMux;
        end
        else
        begin
            wrPend_q <= addrPhase && hwrite;
            rdPend_q <= addrPhase && !hwrite;
            if (addrPhase)
            begin
                addr_q <= haddr[7:0];
            end
            if (addrPhase && !hwrite)
            begin
                hreadyout_q <= 1'b0;
            end
        end
    end

    // route entry index from the address, valid flag alongside
    function automatic logic routeHit(input logic [7:0] a);
        routeHit = a >= REG_ROUTE_BASE && a[1:0] == 2'b00 &&
                   32'(a - REG_ROUTE_BASE) < 32'(4 * NUM_ROUTE);
    endfunction

    function automatic int routeIdx(input logic [7:0] a);
        routeIdx = int'((a - REG_ROUTE_BASE) >> 2);
    endfunction

    always_comb
    begin
        rdMux = WORD_RESET;
        unique case (addr_q)
            REG_CMD:      rdMux = cmd_q;
            REG_POL:      rdMux = pol_q;
            REG_MAN_EN:   rdMux = manEn_q;
            REG_MAN_VAL:  rdMux = manVal_q;
            REG_READBACK: rdMux = readback_q;
            REG_ROUTE_EN: rdMux = routeEn_q;
            REG_LED_EN:   rdMux = ledEn_q;
            REG_PWM_FREQ: rdMux = pwmFreq_q;
            REG_PWM_DUTY: rdMux = pwmDuty_q;
            default:
            begin
                if (routeHit(addr_q))
                begin
                    rdMux = {16'h0000, route_q[routeIdx(addr_q)]};
                end
            end
        endcase
    end

    // reset clears polarity, manual and routing enable settings
    always_ff @(posedge clock)
    begin
        if (!rst_b)
        begin
            cmd_q     <= WORD_RESET;
            pol_q     <= WORD_RESET;
            manEn_q   <= WORD_RESET;
            manVal_q  <= WORD_RESET;
            routeEn_q <= WORD_RESET;
            ledEn_q   <= WORD_RESET;
        end
        else if (wrPend_q)
        begin
            unique case (addr_q)
                REG_CMD:      cmd_q     <= hwdata;
                REG_POL:      pol_q     <= hwdata;
                REG_MAN_EN:   manEn_q   <= hwdata;
                REG_MAN_VAL:  manVal_q  <= hwdata;
                REG_ROUTE_EN: routeEn_q <= hwdata;
                REG_LED_EN:   ledEn_q   <= hwdata;
                default:      ;
            endcase
        end
    end

    always_ff @(posedge clock)
    begin
        if (!rst_b)
        begin
            pwmFreq_q <= PWM_FREQ_RESET;
            pwmDuty_q <= PWM_DUTY_MAX;
        end
        else if (wrPend_q)
        begin
            if (addr_q == REG_PWM_FREQ && hwdata >= PWM_FREQ_MIN &&
                hwdata <= PWM_FREQ_MAX)
            begin
                pwmFreq_q <= hwdata;
            end
            if (addr_q == REG_PWM_DUTY && hwdata >= PWM_DUTY_MIN &&
                hwdata <= PWM_DUTY_MAX)
            begin
                pwmDuty_q <= hwdata;
            end
        end
    end

    always_ff @(posedge clock)
    begin
        if (!rst_b)
        begin
            for (int j = 0; j < NUM_ROUTE; j++)
            begin
                route_q[j] <= ROUTE_OFF;
            end
        end
        else if (wrPend_q && routeHit(addr_q))
        begin
            route_q[routeIdx(addr_q)] <= hwdata[15:0];
        end
    end

    // brake pwm by phase accumulator
    logic [26:0] phase_q;
    logic [27:0] phaseSum;
    logic        pwmLevel;
    assign phaseSum = 28'(phase_q) + 28'(pwmFreq_q);

    always_ff @(posedge clock)
    begin
        if (!rst_b)
        begin
            phase_q <= 27'h000_0000;
        end
        else if (phaseSum >= 28'(CLK_HZ))
        begin
            phase_q <= 27'(phaseSum - 28'(CLK_HZ));
        end
        else
        begin
            phase_q <= phaseSum[26:0];
        end
    end

    // full duty keeps the level high
    assign pwmLevel = 40'(phase_q) * 40'd100 <
                      40'(CLK_HZ) * 40'(pwmDuty_q[6:0]);

    // single-step changes give one event each
    logic [31:0]        encPrev_q;
    logic [31:0]        posPrev_q;
    logic [31:0]        encDiff;
    logic [31:0]        posDiff;
    logic               encEvt;
    logic               posEvt;
    logic [5:0]         encCnt_q;
    logic [5:0]         posCnt_q;
    logic [5:0]         encCntNext;
    logic [5:0]         posCntNext;
    logic [NUM_DIV-1:0] encDiv;
    logic [NUM_DIV-1:0] posDiv;

    assign encDiff    = encoderCountValue - encPrev_q;
    assign posDiff    = actualPositionValue - posPrev_q;
    assign encEvt     = encDiff == 32'h0000_0001 || encDiff == 32'hFFFF_FFFF;
    assign posEvt     = posDiff == 32'h0000_0001 || posDiff == 32'hFFFF_FFFF;
    assign encCntNext = encCnt_q + 6'h01;
    assign posCntNext = posCnt_q + 6'h01;

    always_ff @(posedge clock)
    begin
        if (!rst_b)
        begin
            encPrev_q <= WORD_RESET;
            posPrev_q <= WORD_RESET;
            encCnt_q  <= 6'h00;
            posCnt_q  <= 6'h00;
        end
        else
        begin
            encPrev_q <= encoderCountValue;
            posPrev_q <= actualPositionValue;
            if (encEvt)
            begin
                encCnt_q <= encCntNext;
            end
            if (posEvt)
            begin
                posCnt_q <= posCntNext;
            end
        end
    end

    // divide by 2^k per encoder and position source
    generate
        for (genvar k = 0; k < NUM_DIV; k++)
        begin : g_div
            localparam logic [5:0] MASK = 6'((1 << k) - 1);
            assign encDiv[k] = encEvt && (encCntNext & MASK) == 6'h00;
            assign posDiv[k] = posEvt && (posCntNext & MASK) == 6'h00;
        end
    endgenerate

    // routing channels: 0 is software pwm, j is output j
    logic [NUM_ROUTE-1:0] routeActive;
    logic [NUM_ROUTE-1:0] routeLevel;
    logic                 routeMode;
    // routing only for the exact value one
    assign routeMode = routeEn_q == ROUTE_EN_VAL;

    generate
        for (genvar j = 0; j < NUM_ROUTE; j++)
        begin : g_route
            localparam int WIDTH = (j == 0) ? SW_PULSE : OUT_PULSE;
            logic [31:0] stretch_q;
            logic        gate;
            logic        srcEvt;
            logic        srcLevel;
            dor_route_t  ent;
            assign ent = route_q[j];
            // channel 0 serves the software pwm pin
            // the disable value takes the channel out
            assign routeActive[j] = routeMode && ent != ROUTE_OFF;
            // invert gating bit when bit 7 set
            assign gate = (ent.ctlBit[6:5] == 2'b00 &&
                           cmd_q[ent.ctlBit[4:0]]) ^ ent.invert;
            always_comb
            begin
                srcEvt   = 1'b0;
                srcLevel = 1'b0;
                if (ent.src >= SRC_ENC_FIRST && ent.src < SRC_POS_FIRST)
                begin
                    srcEvt = encDiv[3'(ent.src - SRC_ENC_FIRST)];
                end
                if (ent.src >= SRC_POS_FIRST && ent.src < SRC_PWM)
                begin
                    srcEvt = posDiv[3'(ent.src - SRC_POS_FIRST)];
                end
                unique case (ent.src)
                    SRC_ONE:     srcLevel = 1'b1;
                    SRC_ZERO:    srcLevel = 1'b0;
                    SRC_PWM:     srcLevel = pwmLevel;
                    SRC_PWM_INV: srcLevel = !pwmLevel;
                    default:     srcLevel = stretch_q != 32'h0000_0000;
                endcase
            end
            // pulses held half a period of the top rate
            always_ff @(posedge clock)
            begin
                if (!rst_b)
                begin
                    stretch_q <= 32'h0000_0000;
                end
                else if (srcEvt)
                begin
                    stretch_q <= 32'(WIDTH);
                end
                else if (stretch_q != 32'h0000_0000)
                begin
                    stretch_q <= stretch_q - 32'h0000_0001;
                end
            end
            // source passes only while gate is on
            assign routeLevel[j] = gate && srcLevel;
        end
    endgenerate

    // pin levels and readback
    logic [NUM_OUT-1:0] outNext;
    logic               brakeNext;
    logic [31:0]        readbackNext;

    assign brakeNext = (manEn_q[BIT_BRAKE] ? manVal_q[BIT_BRAKE]
                                           : cmd_q[BIT_BRAKE])
                       ^ pol_q[BIT_BRAKE];

    generate
        for (genvar i = 0; i < NUM_OUT; i++)
        begin : g_out
            localparam int B = BIT_OUT1 + i;
            assign outNext[i] = routeActive[i+1] ? routeLevel[i+1] :
                                (manEn_q[B] ? manVal_q[B] : cmd_q[B])
                                ^ pol_q[B];
        end
    endgenerate

    always_comb
    begin
        readbackNext = WORD_RESET;
        readbackNext[BIT_BRAKE] = brakeNext;
        readbackNext[BIT_OUT1 +: NUM_OUT] = outNext;
    end

    always_ff @(posedge clock)
    begin
        if (!rst_b)
        begin
            outPin_q   <= '0;
            brakePin_q <= 1'b0;
            swPwmPin_q <= 1'b0;
            readback_q <= WORD_RESET;
        end
        else
        begin
            outPin_q   <= outNext;
            brakePin_q <= brakeNext;
            swPwmPin_q <= routeActive[0] && routeLevel[0];
            readback_q <= readbackNext;
        end
    end

    // led blink timebase
    logic [31:0] blinkCnt_q;
    logic        blink_q;
    always_ff @(posedge clock)
    begin
        if (!rst_b)
        begin
            blinkCnt_q <= 32'h0000_0000;
            blink_q    <= 1'b0;
            ledGreen_q <= 1'b0;
            ledRed_q   <= 1'b0;
        end
        else
        begin
            if (blinkCnt_q >= 32'(LED_BLINK - 1))
            begin
                blinkCnt_q <= 32'h0000_0000;
                blink_q    <= !blink_q;
            end
            else
            begin
                blinkCnt_q <= blinkCnt_q + 32'h0000_0001;
            end
            ledGreen_q <= ledEn_q[BIT_LED_GREEN] && !faultActive && blink_q;
            ledRed_q   <= ledEn_q[BIT_LED_RED] && faultActive && blink_q;
        end
    end

    // checks
    a_brake_cmd: assert property (@(posedge clock) disable iff (!rst_b)
        !manEn_q[BIT_BRAKE] && !pol_q[BIT_BRAKE] |=>
        brakePin_q == $past(cmd_q[BIT_BRAKE]))
        else $error("brake pin does not follow command bit");
    a_out_bit16: assert property (@(posedge clock) disable iff (!rst_b)
        !routeMode && !manEn_q[BIT_OUT1] && !pol_q[BIT_OUT1] |=>
        outPin_q[0] == $past(cmd_q[BIT_OUT1]))
        else $error("output 1 does not follow bit 16");
    a_pol_invert: assert property (@(posedge clock) disable iff (!rst_b)
        !routeMode && pol_q[BIT_OUT1] && !manEn_q[BIT_OUT1] |=>
        outPin_q[0] != $past(cmd_q[BIT_OUT1]))
        else $error("polarity bit does not invert output");
    a_manual_brake: assert property (@(posedge clock) disable iff (!rst_b)
        manEn_q[BIT_BRAKE] |=>
        brakePin_q == ($past(manVal_q[BIT_BRAKE]) ^ $past(pol_q[BIT_BRAKE])))
        else $error("manual value not applied to brake");
    a_readback_pins: assert property (@(posedge clock) disable iff (!rst_b)
        readback_q[BIT_OUT1 +: NUM_OUT] == outPin_q &&
        readback_q[BIT_BRAKE] == brakePin_q)
        else $error("readback differs from pins");
    a_unused_zero: assert property (@(posedge clock) disable iff (!rst_b)
        addrPhase && !hwrite && haddr[7:0] == REG_UNUSED && !rdPend_q |=>
        !hreadyout_q ##1 hreadyout_q && hrdata_q == WORD_RESET)
        else $error("unused entry read not zero after one wait");
    a_led_gate: assert property (@(posedge clock) disable iff (!rst_b)
        !ledEn_q[BIT_LED_GREEN] && !ledEn_q[BIT_LED_RED] |=>
        !ledGreen_q && !ledRed_q)
        else $error("led lit while disabled");
    a_const_one: assert property (@(posedge clock) disable iff (!rst_b)
        routeActive[1] && route_q[1].src == SRC_ONE && g_route[1].gate |=>
        outPin_q[0])
        else $error("constant one source not driven");
    a_full_duty: assert property (@(posedge clock) disable iff (!rst_b)
        pwmDuty_q == PWM_DUTY_MAX |-> pwmLevel)
        else $error("full duty pwm not permanently on");
    a_freq_range: assert property (@(posedge clock) disable iff (!rst_b)
        pwmFreq_q >= PWM_FREQ_MIN && pwmFreq_q <= PWM_FREQ_MAX)
        else $error("pwm frequency outside limits");

    c_route_on: cover property (@(posedge clock) disable iff (!rst_b)
        routeActive[1] ##1 outPin_q[0]);
    c_enc_pulse: cover property (@(posedge clock) disable iff (!rst_b)
        encDiv[2] && routeActive[1]);
    c_manual: cover property (@(posedge clock) disable iff (!rst_b)
        manEn_q[BIT_OUT1] && !cmd_q[BIT_OUT1] ##1 outPin_q[0]);
    c_read: cover property (@(posedge clock) disable iff (!rst_b)
        rdPend_q ##1 hreadyout_q);

endmodule // dor_top

/* File: inc/dor_pkg.sv */
// constants, register map and types of the digital output routing block
package dor_pkg;
    localparam int          NUM_OUT        = 4;
    localparam int          NUM_ROUTE      = NUM_OUT + 1;
    localparam int          NUM_DIV        = 7;
    localparam int          CLK_HZ         = 100_000_000;
    localparam int          CLK_PERIOD_NS  = 10;
    // register byte offsets
    localparam logic [7:0]  REG_CMD        = 8'h00;
    localparam logic [7:0]  REG_UNUSED     = 8'h04;
    localparam logic [7:0]  REG_POL        = 8'h08;
    localparam logic [7:0]  REG_MAN_EN     = 8'h0C;
    localparam logic [7:0]  REG_MAN_VAL    = 8'h10;
    localparam logic [7:0]  REG_READBACK   = 8'h14;
    localparam logic [7:0]  REG_ROUTE_EN   = 8'h18;
    localparam logic [7:0]  REG_LED_EN     = 8'h1C;
    localparam logic [7:0]  REG_PWM_FREQ   = 8'h20;
    localparam logic [7:0]  REG_PWM_DUTY   = 8'h24;
    localparam logic [7:0]  REG_ROUTE_BASE = 8'h40;
    // bit positions in the command and led enable words
    localparam int          BIT_BRAKE      = 0;
    localparam int          BIT_OUT1       = 16;
    localparam int          BIT_LED_GREEN  = 0;
    localparam int          BIT_LED_RED    = 1;
    // reset and special values
    localparam logic [31:0] WORD_RESET     = 32'h0000_0000;
    localparam logic [31:0] ROUTE_EN_VAL   = 32'h0000_0001;
    localparam logic [15:0] ROUTE_OFF      = 16'h0FFF;
    // signal source codes
    localparam logic [7:0]  SRC_ONE        = 8'h00;
    localparam logic [7:0]  SRC_ZERO       = 8'h01;
    localparam logic [7:0]  SRC_ENC_FIRST  = 8'h02;
    localparam logic [7:0]  SRC_POS_FIRST  = 8'h09;
    localparam logic [7:0]  SRC_PWM        = 8'h10;
    localparam logic [7:0]  SRC_PWM_INV    = 8'h11;
    // brake pwm limits
    localparam logic [31:0] PWM_FREQ_MIN   = 32'h0000_0032;
    localparam logic [31:0] PWM_FREQ_MAX   = 32'h0000_4E20;
    localparam logic [31:0] PWM_FREQ_RESET = 32'h0000_03E8;
    localparam logic [31:0] PWM_DUTY_MIN   = 32'h0000_0002;
    localparam logic [31:0] PWM_DUTY_MAX   = 32'h0000_0064;
    // timing: least pulse width is half a period at the top rate
    localparam int          SWPWM_MAX_HZ   = 2000;
    localparam int          OUT_MAX_HZ     = 500;
    localparam int          LED_BLINK_MS   = 250;
    localparam int          SW_PULSE_NS    = 1_000_000_000 / (2 * SWPWM_MAX_HZ);
    localparam int          OUT_PULSE_NS   = 1_000_000_000 / (2 * OUT_MAX_HZ);
    localparam int          SW_PULSE_CYC   =
        (SW_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int          OUT_PULSE_CYC  =
        (OUT_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int          LED_BLINK_CYC  = LED_BLINK_MS * (CLK_HZ / 1000);

    typedef struct packed {
        logic [7:0] src;
        logic       invert;
        logic [6:0] ctlBit;
    } dor_route_t;
endpackage

/* File: testbench/digital_output_routing_test.sv */
// self-checking bench of the digital output routing block
`timescale 1ns/1ps
module digital_output_routing_test
    import dor_pkg::*;
;
    localparam int BLINK = 8;
    localparam int PULSE = 10;
    logic        clock = 0;
    logic        rst_b = 0;
    logic        hsel = 0;
    logic        hwrite = 0;
    logic        faultActive = 0;
    logic [1:0]  htrans = '0;
    logic [2:0]  hsize = 3'h2;
    logic [31:0] haddr = '0;
    logic [31:0] hwdata = '0;
    logic [31:0] encoderCountValue = '0;
    logic [31:0] actualPositionValue = '0;
    logic [31:0] hrdata, rd, lvl, pins;
    logic        hreadyout, hresp, brakePin, swPwmPin, ledGreen, ledRed;
    logic [3:0]  outPin;
    logic [1:0]  seen, held;
    logic [31:0] nv [6];
    int          nFail = 0, cmpCount = 0, seed = 32'h1fd1, riseCount, hi;
    logic [7:0]  cfgReg [7] = '{REG_CMD, REG_POL, REG_MAN_EN, REG_MAN_VAL,
                     REG_UNUSED, REG_READBACK, REG_ROUTE_EN};
    // route enable, entry, command half-word, expected output 1
    logic [63:0] route [9] = '{
        64'h0001_0005_0020_0001, 64'h0001_0005_0000_0000,
        64'h0001_0085_0000_0001, 64'h0001_0085_0020_0000,
        64'h0001_0105_0020_0000, 64'h0001_0FFF_0001_0001,
        64'h0002_0085_0000_0000, 64'h0001_1000_0001_0001,
        64'h0001_1100_0001_0000};
    // address, written value, value read back
    logic [63:0] pwmRow [7] = '{
        64'h0020_0031_0000_03E8, 64'h0020_0032_0000_0032,
        64'h0020_4E21_0000_0032, 64'h0020_4E20_0000_4E20,
        64'h0024_0001_0000_0064, 64'h0024_0065_0000_0064,
        64'h0024_0002_0000_0002};

    always #5 clock = ~clock;

    dor_top #(.SW_PULSE(5), .OUT_PULSE(PULSE), .LED_BLINK(BLINK)) i_dut (
        .clock, .rst_b, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
        .hready(hreadyout), .hrdata, .hreadyout, .hresp, .encoderCountValue,
        .actualPositionValue, .faultActive, .outPin, .brakePin, .swPwmPin,
        .ledGreen, .ledRed);
    dor_load_model i_load (.clock, .rst_b, .outPin, .riseCount);

    task automatic conclude;
        $display("comparisons %0d mismatches %0d", cmpCount, nFail);
        if (nFail == 0 && cmpCount > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        cmpCount++;
        if (g !== e)
        begin
            nFail++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic waitRdy;
        int n;
        n = 0;
        do
        begin
            @(posedge clock);
            n++;
        end
        while (hreadyout !== 1'b1 && n < 50);
        if (hreadyout !== 1'b1)
        begin
            nFail++;
            conclude();
        end
    endtask

    // one single-word transfer; read data lands in rd
    task automatic bus(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        hsel <= 1'b1;
        htrans <= 2'b10;
        hwrite <= w;
        haddr <= {24'h00_0000, a};
        waitRdy();
        htrans <= 2'b00;
        hwdata <= d;
        waitRdy();
        rd = hrdata;
    endtask

    initial
    begin
        #600_000;
        nFail++;
        conclude();
    end

    initial
    begin
        repeat (6) @(posedge clock);
        rst_b <= 1'b1;
        @(posedge clock);
        foreach (cfgReg[i])
        begin
            bus(1'b0, cfgReg[i], '0);
            chk("reset", 32'h0000_0000, rd);
        end
        bus(1'b0, REG_ROUTE_BASE + 8'h04, '0);
        chk("route reset", 32'h0000_0FFF, rd);
        chk("hresp", 32'h0000_0000, 32'(hresp));
        for (int t = 0; t < 8; t++)
        begin
            for (int k = 0; k < 6; k++)
            begin
                nv[k] = $random(seed);
                bus(1'b1, cfgReg[k], nv[k]);
            end
            lvl = ((nv[2] & nv[3]) | (~nv[2] & nv[0])) ^ nv[1];
            lvl = lvl & 32'h000F_0001;
            repeat (2) @(posedge clock);
            pins = {12'h000, outPin, 15'h0000, brakePin};
            chk("pins", lvl, pins);
            bus(1'b0, REG_READBACK, '0);
            chk("readback", lvl, rd);
        end
        bus(1'b1, REG_POL, '0);
        bus(1'b1, REG_MAN_EN, '0);
        $display("test normal path done");
        for (int e = 0; e < 8; e++)
        begin
            faultActive <= e[0];
            bus(1'b1, REG_LED_EN, 32'(e >> 1));
            repeat (2) @(posedge clock);
            seen = '0;
            held = '1;
            repeat (2 * BLINK + 4)
            begin
                @(posedge clock);
                seen = seen | {ledRed, ledGreen};
                held = held & {ledRed, ledGreen};
            end
            lvl = 32'({e[2] & e[0], e[1] & !e[0]});
            chk("leds", lvl, {30'h0000_0000, seen});
            chk("blink", 32'h0000_0000, {30'h0000_0000, held});
        end
        $display("test leds done");
        for (int i = 0; i < 9; i++)
        begin
            bus(1'b1, REG_ROUTE_EN, 32'(route[i][63:48]));
            bus(1'b1, REG_ROUTE_BASE + 8'h04, 32'(route[i][47:32]));
            bus(1'b1, REG_CMD, {2{route[i][31:16]}});
            repeat (2) @(posedge clock);
            lvl = 32'(route[i][15:0]);
            chk("rt", lvl, 32'(outPin[0]));
        end
        bus(1'b1, REG_ROUTE_BASE, 32'h0000_0000);
        for (int c = 0; c < 2; c++)
        begin
            bus(1'b1, REG_CMD, 32'(c));
            repeat (2) @(posedge clock);
            chk("swpwm", 32'(c), 32'(swPwmPin));
        end
        bus(1'b1, REG_ROUTE_BASE + 8'h04, 32'hABCD_1080);
        bus(1'b0, REG_ROUTE_BASE + 8'h04, '0);
        chk("entry", 32'h0000_1080, rd);
        $display("test routing done");
        bus(1'b1, REG_CMD, 32'h0000_0001);
        for (int c = 2; c < 16; c++)
        begin
            bus(1'b1, REG_ROUTE_BASE + 8'h04, 32'(c << 8));
            repeat (3 * PULSE) @(posedge clock);
            hi = riseCount;
            repeat (64)
            begin
                lvl = ($random(seed) & 1) ? 32'h0000_0001 : 32'hFFFF_FFFF;
                if (c < 9)
                    encoderCountValue <= encoderCountValue + lvl;
                else
                    actualPositionValue <= actualPositionValue + lvl;
                repeat (2 * PULSE + 4) @(posedge clock);
            end
            lvl = 32'(64 >> ((c - 2) % 7));
            chk("pulses", lvl, 32'(riseCount - hi));
        end
        $display("test pulses done");
        foreach (pwmRow[i])
        begin
            bus(1'b1, 8'(pwmRow[i][63:48]), 32'(pwmRow[i][47:32]));
            bus(1'b0, 8'(pwmRow[i][63:48]), '0);
            chk("pwm set", pwmRow[i][31:0], rd);
        end
        bus(1'b1, REG_PWM_DUTY, 32'h0000_0019);
        for (int s = 0; s < 2; s++)
        begin
            bus(1'b1, REG_ROUTE_BASE + 8'h04, 32'((16 + s) << 8));
            repeat (4) @(posedge clock);
            hi = 0;
            repeat (CLK_HZ / PWM_FREQ_MAX) @(posedge clock) hi += outPin[0];
            chk("pwm", 32'(25 + 50 * s), 32'((hi + 25) / 50));
        end
        $display("test pwm done");
        conclude();
    end
endmodule // digital_output_routing_test

/* File: testbench/dor_load_model.sv */
// load model on the output pins: counts rising edges of output 1
`timescale 1ns/1ps
module dor_load_model
    import dor_pkg::*;
(
    input  wire logic               clock,
    input  wire logic               rst_b,
    input  wire logic [NUM_OUT-1:0] outPin,
    output int                      riseCount
);
    logic lastLevel_q;

    always_ff @(posedge clock)
    begin
        lastLevel_q <= outPin[0];
        if (!rst_b)
            riseCount <= 0;
        else if (outPin[0] && !lastLevel_q)
            riseCount <= riseCount + 1;
    end
endmodule // dor_load_model
